// ---- hdl/scr_pkg.sv ----
package scr_pkg;

  // register map, byte addresses on the bus
  localparam logic [15:0] SYSTEM_CONFIGURATION_OFFSET = 16'h0000;
  localparam logic [15:0] MEMORY_SPLIT_STATUS_OFFSET  = 16'h0004;
  localparam logic [31:0] SYSTEM_CONFIGURATION_RESET  = 32'h37FF_FF91;

  // field positions inside system_configuration
  localparam int STALL_ON_BIT_POS      = 1;
  localparam int CACHE_ENABLE_POS      = 2;
  localparam int WRITE_BUFFER_POS      = 3;
  localparam int SPLIT_LO_POS          = 4;
  localparam int SRAM_BASE_LO_POS      = 6;
  localparam int SPECIAL_BASE_LO_POS   = 16;
  localparam int PART_ID_LO_POS        = 26;
  localparam int SYNC_DRAM_POS         = 31;

  // bits that hold storage; the rest read back as constants
  localparam logic [31:0] WRITABLE_MASK = 32'h83FF_FFFE;

  // part identifier, value arbitrary
  localparam logic [4:0] PART_IDENTIFIER_FIELD = 5'h0D;

  // special register window: 64 KB, base 0x3ff0000 after reset
  localparam int          SPECIAL_WINDOW_BYTES  = 65536;
  localparam logic [9:0]  SPECIAL_BASE_RESET    = 10'h3FF;

  // depth of the store queue ahead of external memory
  localparam int          WRITE_QUEUE_DEPTH     = 4;

  // cache split encodings
  typedef enum logic [1:0] {
    SCR_SPLIT_HALF   = 2'b00,
    SCR_SPLIT_CACHE  = 2'b01,
    SCR_SPLIT_SRAM   = 2'b10,
    SCR_SPLIT_RSVD   = 2'b11
  } scr_split_type;

  // bus slave states
  typedef enum logic [1:0] {
    SCR_IDLE = 2'b01,
    SCR_DATA = 2'b10
  } scr_state_type;

  // decoded memory configuration handed to cache, sram and dram logic
  typedef struct packed {
    logic [31:0] special_base;
    logic [31:0] sram_base;
    logic [3:0]  sram_kbytes;
    logic [3:0]  cache_kbytes;
    logic        cache_on;
    logic        write_buffer_on;
    logic        sync_dram;
  } scr_memcfg_type;

  // latched address phase
  typedef struct packed {
    logic        write;
    logic [15:0] offset;
  } scr_addr_type;

endpackage : scr_pkg

// ---- hdl/scr_system_config.sv ----
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
module scr_system_config (
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [31:0]           reg_addr,
  output logic                       special_hit,
  output logic      [15:0]           special_offset,
  output logic                       sram_hit,
  output scr_pkg::scr_memcfg_type    memcfg,
  output logic                       store_to_buffer,
  output logic                       write_through
);

  scr_pkg::scr_state_type state;
  scr_pkg::scr_state_type next_state;
  scr_pkg::scr_addr_type  addr_q;
  scr_pkg::scr_addr_type  next_addr_q;
  logic [31:0]            cfg;
  logic [31:0]            next_cfg;
  scr_pkg::scr_memcfg_type next_memcfg;
  logic                   next_special_hit;
  logic [15:0]            next_special_offset;
  logic                   next_sram_hit;
  logic [31:0]            next_hrdata;

  // sram size in KB for a split code
  function automatic logic [3:0] sram_kb(input logic [1:0] split);
    case (split)
      scr_pkg::SCR_SPLIT_HALF:  sram_kb = 4'h4;
      scr_pkg::SCR_SPLIT_CACHE: sram_kb = 4'h0;
      scr_pkg::SCR_SPLIT_SRAM:  sram_kb = 4'h8;
      default:                  sram_kb = 4'h0;
    endcase
  endfunction : sram_kb

  // register readback with constant fields filled in
  function automatic logic [31:0] read_cfg(input logic [31:0] value);
    logic [31:0] r;
    r = value & scr_pkg::WRITABLE_MASK;
    r[scr_pkg::PART_ID_LO_POS +: 5] = scr_pkg::PART_IDENTIFIER_FIELD;
    read_cfg = r;
  endfunction : read_cfg

  // bus slave: one-cycle address phase, zero-wait data phase
  always_comb begin
    next_state  = state;
    next_addr_q = addr_q;
    next_hrdata = 32'h0000_0000;
    if (hready && hsel && htrans[1]) begin
      next_state         = scr_pkg::SCR_DATA;
      next_addr_q.write  = hwrite;
      next_addr_q.offset = haddr[15:0];
    end else if (hready) begin
      next_state = scr_pkg::SCR_IDLE;
    end
    // read data registered from the address phase so hrdata is a flop
    if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[15:0])
        scr_pkg::SYSTEM_CONFIGURATION_OFFSET: next_hrdata = read_cfg(cfg);
        scr_pkg::MEMORY_SPLIT_STATUS_OFFSET: begin
          next_hrdata = {20'h0_0000, memcfg.cache_kbytes, memcfg.sram_kbytes,
                         2'b00, memcfg.cache_on, memcfg.write_buffer_on};
        end
        default: next_hrdata = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state  <= scr_pkg::SCR_IDLE;
      addr_q <= '0;
      hrdata <= 32'h0000_0000;
    end else begin
      state  <= next_state;
      addr_q <= next_addr_q;
      hrdata <= next_hrdata;
    end
  end

  // configuration register; writes land in the data phase
  always_comb begin
    next_cfg = cfg;
    if (state == scr_pkg::SCR_DATA && addr_q.write &&
        addr_q.offset == scr_pkg::SYSTEM_CONFIGURATION_OFFSET) begin
      next_cfg = hwdata & scr_pkg::WRITABLE_MASK;
      // stall bit stored as written; software keeps it zero
      if (hwdata[scr_pkg::SPLIT_LO_POS +: 2] == scr_pkg::SCR_SPLIT_SRAM) begin
        next_cfg[scr_pkg::CACHE_ENABLE_POS] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cfg <= scr_pkg::SYSTEM_CONFIGURATION_RESET & scr_pkg::WRITABLE_MASK;
    end else begin
      cfg <= next_cfg;
    end
  end

  // decoded memory map and policy outputs, registered
  always_comb begin
    next_memcfg.special_base = {6'h00, cfg[scr_pkg::SPECIAL_BASE_LO_POS +: 10], 16'h0000};
    next_memcfg.sram_base    = {6'h00, cfg[scr_pkg::SRAM_BASE_LO_POS +: 10], 16'h0000};
    next_memcfg.sram_kbytes  = sram_kb(cfg[scr_pkg::SPLIT_LO_POS +: 2]);
    next_memcfg.cache_kbytes = 4'h8 - sram_kb(cfg[scr_pkg::SPLIT_LO_POS +: 2]);
    // no flush on re-enable: cache contents are left untouched
    next_memcfg.cache_on     = cfg[scr_pkg::CACHE_ENABLE_POS] &&
                               (next_memcfg.cache_kbytes != 4'h0);
    next_memcfg.write_buffer_on = cfg[scr_pkg::WRITE_BUFFER_POS];
    next_memcfg.sync_dram    = cfg[scr_pkg::SYNC_DRAM_POS];
    // window hit: upper sixteen address bits match the base, low 16 are the offset
    next_special_hit    = (reg_addr[31:16] == next_memcfg.special_base[31:16]);
    next_special_offset = reg_addr[15:0];
    next_sram_hit       = (reg_addr[31:16] == next_memcfg.sram_base[31:16]) &&
                          (reg_addr[15:10] < {2'b00, next_memcfg.sram_kbytes});
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      memcfg          <= '0;
      special_hit     <= 1'b0;
      special_offset  <= 16'h0000;
      sram_hit        <= 1'b0;
      store_to_buffer <= 1'b0;
      write_through   <= 1'b0;
    end else begin
      memcfg          <= next_memcfg;
      special_hit     <= next_special_hit;
      special_offset  <= next_special_offset;
      sram_hit        <= next_sram_hit;
      store_to_buffer <= next_memcfg.write_buffer_on;
      write_through   <= 1'b1; // write hits always go out too
    end
  end

  // always ready, always okay
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule : scr_system_config

// ---- sim/scr_system_config_props.sv ----
`timescale 1ns/10ps
module scr_props (
  input wire logic                   core_clk,
  input wire logic                   reset_n,
  input wire logic [31:0]            reg_addr,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic                   special_hit,
  input wire logic [15:0]            special_offset,
  input wire scr_pkg::scr_memcfg_type memcfg,
  input wire logic                   store_to_buffer,
  input wire logic                   write_through
);
  // one domain, so clock and reset are given once
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rel; $rose(reset_n); endsequence
  property p_bus; hreadyout && !hresp; endproperty
  property p_hit; $past(reset_n) |->
    special_hit == ($past(reg_addr[31:16]) == memcfg.special_base[31:16]); endproperty
  property p_off; $past(reset_n) |-> special_offset == $past(reg_addr[15:0]); endproperty
  property p_rst; s_rel |=> memcfg.special_base == 32'h03FF_0000; endproperty
  property p_clr; memcfg.sram_kbytes == 4'h8 |-> !memcfg.cache_on; endproperty
  property p_sum; $past(reset_n) |-> memcfg.sram_kbytes + memcfg.cache_kbytes == 4'h8; endproperty
  property p_wb; store_to_buffer == memcfg.write_buffer_on; endproperty
  property p_wt; $past(reset_n) |-> write_through; endproperty
  property p_sram; memcfg.sram_base[15:0] == 16'h0000; endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or not okay");
  a_hit: assert property (p_hit) else $error("window hit wrong");
  a_off: assert property (p_off) else $error("window offset wrong");
  a_rst: assert property (p_rst) else $error("window base after reset wrong");
  a_clr: assert property (p_clr) else $error("cache on with no cache");
  a_sum: assert property (p_sum) else $error("split does not total 8 KB");
  a_wb: assert property (p_wb) else $error("store path mismatch");
  a_wt: assert property (p_wt) else $error("write through off");
  a_sram: assert property (p_sram) else $error("sram base low bits set");
endmodule : scr_props
bind scr_system_config scr_props u_props (.core_clk(core_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .hreadyout(hreadyout), .hresp(hresp), .special_hit(special_hit),
  .special_offset(special_offset), .memcfg(memcfg), .store_to_buffer(store_to_buffer),
  .write_through(write_through));

// ---- sim/system_config_register_tb.sv ----
`timescale 1ns/10ps
module system_config_register_tb;
  logic core_clk = 0, reset_n = 0, hwrite = 0, hit, rdy, rsp, srh, stb, wt;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, reg_addr = 32'h0, q, hrdata;
  logic [15:0] offs;
  scr_pkg::scr_memcfg_type memcfg;
  int fails = 0, compares = 0;
  always #20 core_clk = ~core_clk;
  scr_system_config DUT (.core_clk(core_clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
    .hrdata(hrdata), .hreadyout(rdy), .hresp(rsp), .reg_addr(reg_addr), .special_hit(hit),
    .special_offset(offs), .sram_hit(srh), .memcfg(memcfg), .store_to_buffer(stb),
    .write_through(wt));
  task conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one single transfer; request held until hready is seen high
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2; haddr <= a; hwrite <= w;
    @(posedge core_clk); while (rdy !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0; hwdata <= d;
    @(posedge core_clk); while (rdy !== 1'b1) @(posedge core_clk);
    q = hrdata;
  endtask : bus
  // write, then let the decoded outputs settle two cycles later
  task wr(input logic [31:0] d);
    bus(1'b1, 32'h0, d);
    repeat (2) @(posedge core_clk);
  endtask : wr
  function logic [31:0] cfg(input logic sd, input logic [9:0] b, input logic [9:0] s,
                            input logic [1:0] m, input logic wb, input logic ce);
    return {sd, 5'h00, b, s, m, wb, ce, 2'b00}; // stall bit always zero
  endfunction : cfg
  task t_reset;
    bus(1'b0, 32'h0, 32'h0);
    chk("cfg read", 32'h37FF_FF90, q);
    chk("special base", 32'h03FF_0000, memcfg.special_base);
    bus(1'b0, 32'h0000_0010, 32'h0);
    chk("unmapped", 32'h0000_0000, q);
    $display("reset test done");
  endtask : t_reset
  task t_window;
    wr(cfg(1'b0, 10'h300, 10'h3FE, 2'b01, 1'b0, 1'b0));
    reg_addr <= 32'h0300_3014;
    repeat (2) @(posedge core_clk);
    chk("hit moved", 32'h1, {31'h0, hit});
    chk("offset", 32'h3014, {16'h0, offs});
    reg_addr <= 32'h03FF_3014;
    repeat (2) @(posedge core_clk);
    chk("hit old", 32'h0, {31'h0, hit});
    $display("window test done");
  endtask : t_window
  // split codes 0 to 2, not the reserved code, with cache enable written as one
  task t_split;
    logic [3:0] ck [3] = '{4'h4, 4'h8, 4'h0};
    for (int m = 0; m < 3; m++) begin
      wr(cfg(1'b0, 10'h3FF, 10'h3FE, m[1:0], 1'b0, 1'b1));
      bus(1'b0, 32'h0, 32'h0);
      chk("split read", cfg(1'b0, 10'h3FF, 10'h3FE, m[1:0], 1'b0, m != 2) | 32'h3400_0000, q);
      chk("cache kb", {28'h0, ck[m]}, {28'h0, memcfg.cache_kbytes});
      chk("cache on", {31'h0, m != 2}, {31'h0, memcfg.cache_on});
    end
    // cache left off here, as software would before checking dma coherency
    wr(cfg(1'b0, 10'h3FF, 10'h3FE, 2'b01, 1'b0, 1'b0));
    chk("cache off", 32'h0, {31'h0, memcfg.cache_on});
    $display("split test done");
  endtask : t_split
  task t_misc;
    wr(cfg(1'b1, 10'h3FF, 10'h123, 2'b00, 1'b1, 1'b0));
    chk("sdram", 32'h1, {31'h0, memcfg.sync_dram});
    chk("buffer", 32'h1, {31'h0, stb});
    chk("sram base", 32'h0123_0000, memcfg.sram_base);
    // last kilobyte of the 4 KB sram half hits, the next one does not
    reg_addr <= 32'h0123_0C00;
    repeat (2) @(posedge core_clk);
    chk("sram hit", 32'h1, {31'h0, srh});
    reg_addr <= 32'h0123_1000;
    repeat (2) @(posedge core_clk);
    chk("sram miss", 32'h0, {31'h0, srh});
    $display("misc test done");
  endtask : t_misc
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_reset;
    t_window;
    t_split;
    t_misc;
    conclude;
  end
  // watchdog well past the roughly fifty cycles the tests need
  initial begin
    #400000;
    fails++;
    conclude;
  end
endmodule : system_config_register_tb
